// >>> src/incskip_or_movlit_exec.sv
// Execute stage for increment-skip, OR with file, OR with literal and load literal
//
// Notes on behaviour
// [RULE1] Increment-skip adds one to file; d picks working or file; flags untouched.
// [RULE2] A zero increment result discards the already fetched next instruction.
// [RULE3] The discarded slot runs as a no-op: one cycle, or two when skipping.
// [RULE4] OR-with-file ORs working and file into d's target and updates zero.
// [RULE5] Load-literal copies the eight-bit literal into working; flags untouched.
// [RULE6] Fetch fills load-literal don't-cares with zero; decode ignores them anyway.
// [RULE7] OR-with-literal ORs working with literal into working and updates zero.
`timescale 1ns/1ps
module incskip_or_movlit_exec
(
    // Clock and reset
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_reset,
    // Instruction from the fetch stage
    input  wire logic [exec_pkg::INSTR_W-1:0] i_instr,
    input  wire logic                         i_instr_valid,
    // File register read port (combinational read)
    output logic      [exec_pkg::FADDR_W-1:0] o_file_rd_addr,
    input  wire logic [exec_pkg::DATA_W-1:0]  i_file_rd_data,
    // File register write port
    output logic                              o_file_wr_en,
    output logic      [exec_pkg::FADDR_W-1:0] o_file_wr_addr,
    output logic      [exec_pkg::DATA_W-1:0]  o_file_wr_data,
    // Core state and status
    output logic      [exec_pkg::DATA_W-1:0]  o_working,
    output logic                              o_zero,
    output logic                              o_skip_pending,
    output logic                              o_discard,
    output logic                              o_unsupported
);

    // ========================================================
    // Decode
    // ========================================================
    decode_if dec ();

    instr_decoder u_decoder
    (
        .dec (dec)
    );

    // The decoder always looks at the word on the fetch bus
    assign dec.instr = i_instr;

    // ========================================================
    // State registers
    // ========================================================
    // Working register and zero flag
    logic [exec_pkg::DATA_W-1:0]  working_r;
    logic [exec_pkg::DATA_W-1:0]  working_nxt;
    logic                         zero_r;
    logic                         zero_nxt;

    // Skip control
    logic                         skip_r;
    logic                         skip_nxt;

    // File write port
    logic                         wr_en_r;
    logic                         wr_en_nxt;
    logic [exec_pkg::FADDR_W-1:0] wr_addr_r;
    logic [exec_pkg::FADDR_W-1:0] wr_addr_nxt;
    logic [exec_pkg::DATA_W-1:0]  wr_data_r;
    logic [exec_pkg::DATA_W-1:0]  wr_data_nxt;

    // Diagnostics
    logic                         unsup_r;
    logic                         unsup_nxt;

    // ========================================================
    // Slot qualification
    // ========================================================
    // A pending skip turns the next valid slot into a no-op; idle cycles
    // leave it armed, so fetch may stall between the skip and its victim
    wire slot_discard = i_instr_valid && skip_r;                // [RULE2]
    wire slot_exec    = i_instr_valid && !skip_r;

    wire do_inc_skip  = slot_exec && (dec.op == exec_pkg::OP_INC_SKIP);
    wire do_or_file   = slot_exec && (dec.op == exec_pkg::OP_OR_FILE);
    wire do_or_lit    = slot_exec && (dec.op == exec_pkg::OP_OR_LIT);
    wire do_load_lit  = slot_exec && (dec.op == exec_pkg::OP_LOAD_LIT);
    wire do_none      = slot_exec && (dec.op == exec_pkg::OP_NONE);

    // ========================================================
    // Operand fetch with write bypass
    // ========================================================
    // The file write lands one edge late, so a back-to-back read of the
    // same register would see stale data without this forward path
    wire bypass_hit = wr_en_r && (wr_addr_r == dec.faddr);
    wire [exec_pkg::DATA_W-1:0] file_val = bypass_hit ? wr_data_r : i_file_rd_data;

    assign o_file_rd_addr = dec.faddr;

    // ========================================================
    // Arithmetic and logic results
    // ========================================================
    // Increment wraps at eight bits; the carry is dropped on purpose
    wire [exec_pkg::DATA_W-1:0] inc_result   = file_val + exec_pkg::DATA_ONE;  // [RULE1]
    wire [exec_pkg::DATA_W-1:0] or_file_res  = working_r | file_val;           // [RULE4]
    wire [exec_pkg::DATA_W-1:0] or_lit_res   = working_r | dec.literal;        // [RULE7]
    wire                        inc_is_zero  = (inc_result == exec_pkg::DATA_ZERO);
    wire                        or_file_zero = (or_file_res == exec_pkg::DATA_ZERO);
    wire                        or_lit_zero  = (or_lit_res == exec_pkg::DATA_ZERO);

    // Destination steering for the two file-register forms
    wire to_file    = (dec.dest_file == exec_pkg::DEST_FILE);
    wire to_working = (dec.dest_file == exec_pkg::DEST_WORKING);

    // ========================================================
    // Next-state selection
    // ========================================================
    // Working register: file forms write it only when d selects working
    assign working_nxt = (do_inc_skip && to_working) ? inc_result :   // [RULE1]
                         (do_or_file  && to_working) ? or_file_res :  // [RULE4]
                         do_or_lit                   ? or_lit_res  :  // [RULE7]
                         do_load_lit                 ? dec.literal :  // [RULE5]
                                                       working_r;

    // ========================================================
    // Status flag
    // ========================================================
    // Zero flag: only the two OR forms touch it; increment and load leave it
    assign zero_nxt = do_or_file ? or_file_zero :                    // [RULE4]
                      do_or_lit  ? or_lit_zero  :                    // [RULE7]
                                   zero_r;                           // [RULE1] [RULE5]

    // ========================================================
    // Skip control
    // ========================================================
    // Skip is armed by a zero increment and spent by the next valid slot.
    // Arming needs an executed slot, so arm and spend never meet in one cycle
    assign skip_nxt = do_inc_skip   ? inc_is_zero :                  // [RULE2]
                      slot_discard  ? 1'b0        :                  // [RULE3]
                                      skip_r;

    // ========================================================
    // File write back
    // ========================================================
    // Address and data follow every file form; only the enable looks at d,
    // so the port shows the last file-form result even when it went to working
    wire file_form     = do_inc_skip || do_or_file;
    assign wr_en_nxt   = file_form && to_file;                       // [RULE1] [RULE4]
    assign wr_addr_nxt = file_form ? dec.faddr : wr_addr_r;
    assign wr_data_nxt = do_inc_skip ? inc_result  :                 // [RULE1]
                         do_or_file  ? or_file_res :                 // [RULE4]
                                       wr_data_r;

    // ========================================================
    // Diagnostics
    // ========================================================
    // Words outside the four handled opcodes are flagged and otherwise ignored
    assign unsup_nxt = do_none;

    // ========================================================
    // Core state flops
    // ========================================================
    // Working register and zero flag
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            working_r <= exec_pkg::W_RESET;
            zero_r    <= exec_pkg::Z_RESET;
        end
        else
        begin
            working_r <= working_nxt;
            zero_r    <= zero_nxt;
        end
    end

    // Skip state; a reset drops any pending discard
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            skip_r <= 1'b0;
        end
        else
        begin
            skip_r <= skip_nxt;
        end
    end

    // Write port and diagnostic flops
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= exec_pkg::FADDR_RESET;
            wr_data_r <= exec_pkg::DATA_ZERO;
            unsup_r   <= 1'b0;
        end
        else
        begin
            wr_en_r   <= wr_en_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            unsup_r   <= unsup_nxt;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    // Discard is a handshake back to fetch, so it stays combinational
    assign o_discard      = slot_discard;                            // [RULE3]
    assign o_skip_pending = skip_r;

    // Core state straight from the flops
    assign o_working      = working_r;
    assign o_zero         = zero_r;

    // Registered write port, so the array sees a clean one-cycle strobe
    assign o_file_wr_en   = wr_en_r;
    assign o_file_wr_addr = wr_addr_r;
    assign o_file_wr_data = wr_data_r;

    // Diagnostic pulse for words outside the handled set
    assign o_unsupported  = unsup_r;

endmodule

// >>> common/exec_pkg.sv
// Shared constants for the four-instruction execute block
package exec_pkg;

    // ========================================================
    // Word and field geometry
    // ========================================================
    localparam int unsigned INSTR_W     = 14;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned FADDR_W     = 7;
    localparam int unsigned OPC_HI      = 13;
    localparam int unsigned OPC6_LO     = 8;
    localparam int unsigned OPC4_LO     = 10;
    localparam int unsigned DEST_BIT    = 7;
    localparam int unsigned FADDR_HI    = 6;
    localparam int unsigned LIT_HI      = 7;

    // ========================================================
    // Opcode patterns
    // ========================================================
    // Six-bit major opcodes in bits 13..8
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f; // 00 1111
    localparam logic [5:0] OPC_OR_FILE  = 6'h04; // 00 0100
    localparam logic [5:0] OPC_OR_LIT   = 6'h38; // 11 1000
    // Four-bit opcode in bits 13..10; bits 9..8 are don't care
    localparam logic [3:0] OPC_LOAD_LIT = 4'hc;  // 11 00xx

    // ========================================================
    // Destination encoding and reset values
    // ========================================================
    localparam logic             DEST_WORKING = 1'b0;
    localparam logic             DEST_FILE    = 1'b1;
    localparam logic [DATA_W-1:0]  W_RESET     = 8'h00;
    localparam logic               Z_RESET     = 1'b0;
    localparam logic [DATA_W-1:0]  DATA_ZERO   = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_ONE    = 8'h01;
    localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;

    // Operation selected by the decoder
    typedef enum logic [2:0] {
        OP_NONE,
        OP_INC_SKIP,
        OP_OR_FILE,
        OP_OR_LIT,
        OP_LOAD_LIT
    } exec_op_t;

endpackage

// >>> common/decode_if.sv
// Decoded instruction fields passed from the decoder to the execute logic
`timescale 1ns/1ps
interface decode_if;
    logic [exec_pkg::INSTR_W-1:0] instr;
    exec_pkg::exec_op_t           op;
    logic                         dest_file;
    logic [exec_pkg::FADDR_W-1:0] faddr;
    logic [exec_pkg::DATA_W-1:0]  literal;

    modport decoder (input instr, output op, output dest_file, output faddr, output literal);
    modport exec    (output instr, input op, input dest_file, input faddr, input literal);
endinterface

// >>> src/instr_decoder.sv
// Opcode and field decoder for the four supported instructions
`timescale 1ns/1ps
module instr_decoder
(
    // Decoded fields
    decode_if.decoder dec
);

    // ========================================================
    // Opcode match
    // ========================================================
    // Field extraction
    wire [5:0] opc6 = dec.instr[exec_pkg::OPC_HI:exec_pkg::OPC6_LO];
    wire [3:0] opc4 = dec.instr[exec_pkg::OPC_HI:exec_pkg::OPC4_LO];

    // Load literal compares only bits 13..10, so the don't-care pair never changes its result
    wire hit_inc_skip = (opc6 == exec_pkg::OPC_INC_SKIP);
    wire hit_or_file  = (opc6 == exec_pkg::OPC_OR_FILE);
    wire hit_or_lit   = (opc6 == exec_pkg::OPC_OR_LIT);
    wire hit_load_lit = (opc4 == exec_pkg::OPC_LOAD_LIT); // [RULE6]

    // Patterns are disjoint, so the priority order is immaterial
    assign dec.op = hit_inc_skip ? exec_pkg::OP_INC_SKIP :
                    hit_or_file  ? exec_pkg::OP_OR_FILE  :
                    hit_or_lit   ? exec_pkg::OP_OR_LIT   :
                    hit_load_lit ? exec_pkg::OP_LOAD_LIT :
                                   exec_pkg::OP_NONE;

    // Operand fields
    assign dec.dest_file = dec.instr[exec_pkg::DEST_BIT];
    assign dec.faddr     = dec.instr[exec_pkg::FADDR_HI:0];
    assign dec.literal   = dec.instr[exec_pkg::LIT_HI:0];

endmodule

// >>> verification/file_model.sv
// Behavioural file register array that sits on the far side of the execute block
`timescale 1ns/1ps
module file_model
(
    // Clock
    input  wire logic                         i_ref_clk,
    // Read port
    input  wire logic [exec_pkg::FADDR_W-1:0] i_rd_addr,
    output logic      [exec_pkg::DATA_W-1:0]  o_rd_data,
    // Write port
    input  wire logic                         i_wr_en,
    input  wire logic [exec_pkg::FADDR_W-1:0] i_wr_addr,
    input  wire logic [exec_pkg::DATA_W-1:0]  i_wr_data
);
    logic [exec_pkg::DATA_W-1:0] mem [128];
    // Starts cleared so that the bench model can mirror it without peeking
    initial foreach (mem[i]) mem[i] = 8'h00;
    // No forwarding here: a same-address read just after a write sees the old value
    assign o_rd_data = mem[i_rd_addr];
    always @(posedge i_ref_clk) if (i_wr_en) mem[i_wr_addr] <= i_wr_data;
endmodule

// >>> verification/exec_props.sv
// Port-level concurrent checks for the execute block
`timescale 1ns/1ps
module exec_props
(
    // Watched ports
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic [13:0] i_instr,
    input wire logic        i_instr_valid,
    input wire logic [6:0]  o_file_rd_addr,
    input wire logic [7:0]  i_file_rd_data,
    input wire logic        o_file_wr_en,
    input wire logic [6:0]  o_file_wr_addr,
    input wire logic [7:0]  o_file_wr_data,
    input wire logic [7:0]  o_working,
    input wire logic        o_zero,
    input wire logic        o_skip_pending,
    input wire logic        o_discard,
    input wire logic        o_unsupported
);
    // Forwarded reads are left out: the read port then shows a stale value
    wire ok_w  = i_instr_valid & ~o_discard & ~(o_file_wr_en & (o_file_wr_addr == i_instr[6:0]));
    wire inc_w = ok_w & (i_instr[13:8] == exec_pkg::OPC_INC_SKIP);
    wire orf_w = ok_w & (i_instr[13:8] == exec_pkg::OPC_OR_FILE);
    wire orl_w = i_instr_valid & ~o_discard & (i_instr[13:8] == exec_pkg::OPC_OR_LIT);
    wire ldl_w = i_instr_valid & ~o_discard & (i_instr[13:10] == exec_pkg::OPC_LOAD_LIT);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_discard_tied: assert property (o_discard == (i_instr_valid & o_skip_pending))
        else $error("discard not tied to pending skip");
    a_rd_addr_field: assert property (o_file_rd_addr == i_instr[6:0])
        else $error("file read address not taken from operand field");
    a_skip_on_zero: assert property (inc_w && i_file_rd_data == 8'hff
        |=> o_skip_pending)
        else $error("zero increment did not arm skip");
    a_no_skip: assert property (inc_w && i_file_rd_data != 8'hff |=> !o_skip_pending)
        else $error("nonzero increment armed skip");
    a_inc_dest: assert property (inc_w |=> $stable(o_zero) && ($past(i_instr[7]) ?
        (o_file_wr_en && $stable(o_working) && o_file_wr_data == $past(i_file_rd_data) + 8'h01)
        : (!o_file_wr_en && o_working == $past(i_file_rd_data) + 8'h01)))
        else $error("increment result or target wrong");
    a_discard_noop: assert property (o_discard |=> !o_skip_pending ##0 !o_file_wr_en
        ##0 ($stable(o_working) && $stable(o_zero)))
        else $error("discarded slot changed state");
    a_or_file_res: assert property (orf_w |=>
        o_zero == (($past(o_working) | $past(i_file_rd_data)) == 8'h00)
        && ($past(i_instr[7])
        ? (o_file_wr_en && $stable(o_working)
            && o_file_wr_data == ($past(o_working) | $past(i_file_rd_data)))
        : (o_working == ($past(o_working) | $past(i_file_rd_data)))))
        else $error("or with file result wrong");
    a_or_lit_res: assert property (orl_w |=>
        o_working == ($past(o_working) | $past(i_instr[7:0]))
        && o_zero == (o_working == 8'h00) && !o_file_wr_en)
        else $error("or with literal result wrong");
    a_load_lit_val: assert property (ldl_w |=>
        o_working == $past(i_instr[7:0]) && $stable(o_zero))
        else $error("load literal result wrong");
endmodule
bind incskip_or_movlit_exec exec_props chk_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_instr(i_instr), .i_instr_valid(i_instr_valid), .o_file_rd_addr(o_file_rd_addr),
    .i_file_rd_data(i_file_rd_data), .o_file_wr_en(o_file_wr_en), .o_file_wr_addr(o_file_wr_addr),
    .o_file_wr_data(o_file_wr_data), .o_working(o_working), .o_zero(o_zero),
    .o_skip_pending(o_skip_pending), .o_discard(o_discard), .o_unsupported(o_unsupported));

// >>> verification/incskip_or_movlit_exec_tb_top.sv
// Self-checking bench: execute block against an integer reference model
`timescale 1ns/1ps
module incskip_or_movlit_exec_tb_top;
    logic        i_ref_clk     = 1'b0;
    logic        i_reset       = 1'b1;
    logic [13:0] i_instr       = 14'h0000;
    logic        i_instr_valid = 1'b0;
    logic [6:0]  rd_addr, wr_addr;
    logic [7:0]  rd_data, wr_data, working;
    logic        wr_en, zero, skip, discard, unsup;
    int          mismatches = 0;
    int          compares   = 0;
    int          m_w, m_z, m_s, m_we, m_wa, m_wd, m_u, k;
    int          mem [128];
    logic [13:0] w_rand;
    logic [14:0] table_q [$] = '{15'h70ff, 15'h4483, 15'h4f83, 15'h0000, 15'h705a, 15'h4f03,
        15'h7835, 15'h7000, 15'h7800, 15'h705a, 15'h4403, 15'h4000, 15'h7fff};
    always #5 i_ref_clk = ~i_ref_clk;
    incskip_or_movlit_exec dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .o_file_rd_addr(rd_addr), .i_file_rd_data(rd_data),
        .o_file_wr_en(wr_en), .o_file_wr_addr(wr_addr), .o_file_wr_data(wr_data),
        .o_working(working), .o_zero(zero), .o_skip_pending(skip), .o_discard(discard),
        .o_unsupported(unsup));
    file_model file_u (.i_ref_clk(i_ref_clk), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
        .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data));
    // ==========
    // Compare tasks and reference model
    task automatic chk(input logic [7:0] got, input int exp);
        compares++;
        if (got !== exp[7:0]) mismatches++;
        if (got !== exp[7:0]) $display("BAD t=%0t got=%h exp=%h", $time, got, exp[7:0]);
    endtask
    task automatic chk1(input logic got, input int exp);
        chk({7'h00, got}, exp);
    endtask
    // Result goes to file when d is set, else to working; the write port
    // latches address and data for every file form
    task automatic put(input int f, input int r, input logic d);
        m_wa = f;
        m_wd = r;
        if (d)
        begin
            mem[f] = r;
            m_we = 1;
        end
        else
            m_w = r;
    endtask
    task automatic apply(input logic [13:0] w, input logic v);
        int res;
        m_we = 0;
        m_u = 0;
        res = (mem[w[6:0]] + 1) % 256;
        if (v && m_s) m_s = 0;
        else if (v && w[13:8] == exec_pkg::OPC_INC_SKIP)
        begin
            put(w[6:0], res, w[7]);
            m_s = (res == 0);
        end
        else if (v && w[13:8] == exec_pkg::OPC_OR_FILE)
        begin
            m_z = ((m_w | mem[w[6:0]]) == 0);
            put(w[6:0], m_w | mem[w[6:0]], w[7]);
        end
        else if (v && w[13:8] == exec_pkg::OPC_OR_LIT)
        begin
            m_w = m_w | w[7:0];
            m_z = (m_w == 0);
        end
        else if (v && w[13:10] == exec_pkg::OPC_LOAD_LIT) m_w = w[7:0];
        else m_u = v;
    endtask
    task automatic check_state();
        chk(working, m_w);
        chk1(zero, m_z);
        chk1(skip, m_s);
        chk1(wr_en, m_we);
        chk({1'b0, wr_addr}, m_wa);
        chk(wr_data, m_wd);
        chk1(unsup, m_u);
    endtask
    // One slot per call: drive on the edge, then check what earlier slots left behind
    task automatic run(input logic [13:0] w, input logic v);
        @(posedge i_ref_clk);
        i_instr <= w;
        i_instr_valid <= v;
        #1;
        check_state();
        chk1(discard, v && m_s);
        apply(w, v);
    endtask
    task automatic do_reset();
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        i_instr_valid <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1;
        {m_w, m_z, m_s, m_we, m_wa, m_wd, m_u} = 224'h0;
        check_state();
    endtask
    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========
    // Main sequence: directed skip and flag cases, then random traffic, then reset again
    initial
    begin
        k = $urandom(32'h1e0c683d);
        do_reset();
        foreach (table_q[i]) run(table_q[i][13:0], table_q[i][14]);
        $display("directed test done");
        repeat (3000)
        begin
            k = $urandom();
            case (k[18:16])
                0, 1: w_rand = {exec_pkg::OPC_INC_SKIP, k[7], 4'h0, k[2:0]};
                2: w_rand = {exec_pkg::OPC_OR_FILE, k[7], 4'h0, k[2:0]};
                3: w_rand = {exec_pkg::OPC_OR_LIT, k[7:0]};
                4: w_rand = {exec_pkg::OPC_LOAD_LIT, 2'b00, k[7:0]};
                default: w_rand = k[13:0];
            endcase
            run(w_rand, k[23:20] != 4'h0);
        end
        // One idle slot so the last random word is checked too
        run(14'h0000, 1'b0);
        $display("random test done");
        do_reset();
        $display("reset test done");
        report_and_stop();
    end
endmodule
